// [hw/pcg_defines.svh]
/*
  Offsets, field positions, reset values and masks of the peripheral clock gate block.
  Assumes a word-addressed register port where byte address = offset.
*/
`ifndef PCG_DEFINES_SVH
`define PCG_DEFINES_SVH

`define PCG_SYSCTL_BASE      32'h400fe000
`define PCG_RUN_GATE_OFF     12'h104
`define PCG_SLEEP_GATE_OFF   12'h114
`define PCG_DSLP_GATE_OFF    12'h124
`define PCG_RUN_CFG_OFF      12'h060
`define PCG_IRQ_STAT_OFF     12'h200
`define PCG_IRQ_MASK_OFF     12'h204
`define PCG_MODE_OFF         12'h208

`define PCG_BIT_SERIAL0      0
`define PCG_BIT_SERIAL1      1
`define PCG_BIT_SYNC0        4
`define PCG_BIT_SYNC1        5
`define PCG_BIT_ENCODER0     8
`define PCG_BIT_TWO_WIRE0    12
`define PCG_BIT_COMPARATOR0_GATE        24
`define PCG_BIT_COMPARATOR1_GATE        25
`define PCG_BIT_COMPARATOR2_GATE        26
`define PCG_BIT_AUTO_GATING  27

`define PCG_GATE_MASK        32'h07001133
`define PCG_GATE_RESET       32'h00000000
`define PCG_CFG_RESET        32'h00000000
`define PCG_UNITS            9

`define PCG_IRQ_FAULT_BIT    0
`define PCG_IRQ_CHANGE_BIT   1
`define PCG_IRQ_MASK_BITS    32'h00000003
`endif

// [hw/pcg_pkg.sv]
/*
  Types of the peripheral clock gate block.
  Assumes pcg_defines.svh is compiled alongside.
*/
package pcg_pkg;

  typedef enum logic [1:0]
  {
    PCG_MODE_RUN   = 2'h0,
    PCG_MODE_SLEEP = 2'h1,
    PCG_MODE_DEEP  = 2'h2
  } pcg_mode_type;

  typedef struct packed
  {
    logic [31:0]  run_gate;
    logic [31:0]  sleep_gate;
    logic [31:0]  dslp_gate;
    logic         auto_gating;
    logic [8:0]   unit_en;
    logic [31:0]  rdata;
    logic         fault;
    logic [1:0]   irq_stat;
    logic [1:0]   irq_mask;
    logic         irq;
  } pcg_state_type;

endpackage : pcg_pkg

// [hw/pcg_top.sv]
/*
  Peripheral clock gating, first register set: run, sleep and deep-sleep gate
  registers, gate selection by power mode, bus fault check for gated units.
  Assumes one clock, a synchronous power-mode input from the power controller
  and a one-cycle peripheral access strobe from the bus fabric.
*/
// Added by the designer: the strobed register port.
// Function
// - Each unit is clocked only while its applied gate bit is one.
// - Access to a unit whose gate is off answers with a bus fault.
// - All gate bits reset to zero, every unit unclocked.
// - Three identical gate registers: run, sleep, deep sleep, by power mode.
// - Sleep and deep-sleep registers apply only with automatic gating selected.
// - Deep-sleep gate register sits at offset 0x124, read and write.
// - Bit 1 gates serial port 1, read/write, resets zero.
// - Bit 0 gates serial port 0, read/write, resets zero.
// - Reserved bits are read-only zero; software preserves them.
// - Bits without a unit affect no clock.
`include "pcg_defines.svh"

module pcg_top
#(
  parameter int unsigned UNITS = `PCG_UNITS
)
(
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 resetn,
  // Register port
  input  wire logic [11:0]          reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_write,
  input  wire logic                 reg_read,
  output logic      [31:0]          reg_rdata,
  // Power mode and peripheral access check
  input  wire logic [1:0]           power_mode,
  input  wire logic                 unit_access,
  input  wire logic [3:0]           unit_select,
  output logic                      unit_fault,
  // Unit clock enables and interrupt
  output logic      [UNITS-1:0]     unit_clock_en,
  output logic                      irq
);

  pcg_pkg::pcg_state_type st_q;
  pcg_pkg::pcg_state_type st_d;

  // Packs the implemented gate bits into the unit enable order
  function automatic logic [8:0] pcg_units(input logic [31:0] g);
    pcg_units = {g[`PCG_BIT_COMPARATOR2_GATE], g[`PCG_BIT_COMPARATOR1_GATE], g[`PCG_BIT_COMPARATOR0_GATE],
                 g[`PCG_BIT_TWO_WIRE0], g[`PCG_BIT_ENCODER0],
                 g[`PCG_BIT_SYNC1], g[`PCG_BIT_SYNC0],
                 g[`PCG_BIT_SERIAL1], g[`PCG_BIT_SERIAL0]};
  endfunction : pcg_units

  logic [31:0]  wgate;
  logic [31:0]  sel_gate;
  logic [8:0]   new_en;
  logic [1:0]   events;

  always_comb
  begin
    st_d     = st_q;
    wgate    = reg_wdata & `PCG_GATE_MASK;
    events   = 2'h0;
    if (reg_write)
    begin
      case (reg_addr)
        `PCG_RUN_GATE_OFF:   st_d.run_gate = wgate;
        `PCG_SLEEP_GATE_OFF: st_d.sleep_gate = wgate;
        `PCG_DSLP_GATE_OFF:  st_d.dslp_gate = wgate;
        `PCG_RUN_CFG_OFF:    st_d.auto_gating = reg_wdata[`PCG_BIT_AUTO_GATING];
        `PCG_IRQ_MASK_OFF:   st_d.irq_mask = reg_wdata[1:0];
        `PCG_IRQ_STAT_OFF:   st_d.irq_stat = st_q.irq_stat & ~reg_wdata[1:0];
        default:             st_d.irq_stat = st_d.irq_stat;
      endcase
    end
    st_d.rdata = 32'h00000000;
    if (reg_read)
    begin
      case (reg_addr)
        `PCG_RUN_GATE_OFF:   st_d.rdata = st_q.run_gate;
        `PCG_SLEEP_GATE_OFF: st_d.rdata = st_q.sleep_gate;
        `PCG_DSLP_GATE_OFF:  st_d.rdata = st_q.dslp_gate;
        `PCG_RUN_CFG_OFF:    st_d.rdata = {4'h0, st_q.auto_gating, 27'h0000000};
        `PCG_IRQ_STAT_OFF:   st_d.rdata = {30'h00000000, st_q.irq_stat};
        `PCG_IRQ_MASK_OFF:   st_d.rdata = {30'h00000000, st_q.irq_mask};
        `PCG_MODE_OFF:       st_d.rdata = {30'h00000000, power_mode};
        default:             st_d.rdata = 32'h00000000;
      endcase
    end
    // Mode picks the applied register only under automatic gating
    case (pcg_pkg::pcg_mode_type'(power_mode))
      pcg_pkg::PCG_MODE_SLEEP: sel_gate = st_q.auto_gating ? st_q.sleep_gate
                                                           : st_q.run_gate;
      pcg_pkg::PCG_MODE_DEEP:  sel_gate = st_q.auto_gating ? st_q.dslp_gate
                                                           : st_q.run_gate;
      default:                 sel_gate = st_q.run_gate;
    endcase
    // Registered enable changes only at a clock edge, so no partial pulse
    new_en = pcg_units(sel_gate);
    st_d.unit_en = new_en;
    events[1] = (new_en != st_q.unit_en);
    // Fault when the addressed unit is not clocked
    st_d.fault = 1'b0;
    if (unit_access)
    begin
      if (unit_select >= 4'(UNITS))
        st_d.fault = 1'b1;
      else
        st_d.fault = ~st_q.unit_en[unit_select];
    end
    events[0] = st_d.fault;
    st_d.irq_stat = st_d.irq_stat | events;
    st_d.irq = |(st_d.irq_stat & st_d.irq_mask);
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q             <= '0;
      st_q.run_gate    <= `PCG_GATE_RESET;
      st_q.sleep_gate  <= `PCG_GATE_RESET;
      st_q.dslp_gate   <= `PCG_GATE_RESET;
      st_q.auto_gating <= 1'b0;
    end
    else
      st_q <= st_d;
  end

  assign reg_rdata     = st_q.rdata;
  assign unit_fault    = st_q.fault;
  assign unit_clock_en = st_q.unit_en[UNITS-1:0];
  assign irq           = st_q.irq;

endmodule : pcg_top

// [tb/pcg_assertions.sv]
/* Port assertions of pcg_top.
   Bound into every pcg_top; one clock, reset active low. */
module pcg_checker
#(parameter int unsigned UNITS = 9)
(
  // Watched ports
  input wire logic clock,
  input wire logic resetn,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic [1:0] power_mode,
  input wire logic unit_access,
  input wire logic [3:0] unit_select,
  input wire logic unit_fault,
  input wire logic [UNITS-1:0] unit_clock_en
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_off; unit_access && !unit_clock_en[unit_select] |=> unit_fault; endproperty
  a_off: assert property (p_off) else $error("no fault");
  property p_on; unit_access && unit_clock_en[unit_select] |=> !unit_fault; endproperty
  a_on: assert property (p_on) else $error("bad fault");
  property p_src; unit_fault |-> $past(unit_access); endproperty
  a_src: assert property (p_src) else $error("stray fault");
  property p_rst; $rose(resetn) |-> unit_clock_en == '0; endproperty
  a_rst: assert property (p_rst) else $error("gate open");
  property p_idle; !$past(reg_read) |-> reg_rdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("stray data");
  property p_wr; reg_write && reg_addr == 12'h124 ##1 !reg_write ##1 reg_read &&
    reg_addr == 12'h124 |=> reg_rdata == ($past(reg_wdata, 3) & 32'h07001133); endproperty
  a_wr: assert property (p_wr) else $error("read back");
  property p_run; reg_write && reg_addr == 12'h104 && power_mode == 2'h0 ##1 !reg_write
    |=> unit_clock_en[1:0] == 2'($past(reg_wdata, 2)); endproperty
  a_run: assert property (p_run) else $error("run gate");
  property p_hold; !reg_write && $stable(power_mode) ##1 !reg_write && $stable(power_mode)
    |=> $stable(unit_clock_en); endproperty
  a_hold: assert property (p_hold) else $error("gate moved");
  cover property (unit_fault);
  cover property (reg_read);
  cover property (reg_write);
endmodule : pcg_checker

bind pcg_top pcg_checker #(.UNITS(UNITS)) i_pcg_checker (.*);

// [tb/peripheral_clock_gating_set1_tb.sv]
/* Bench for pcg_top; drives all its ports, checker bound in. */
module peripheral_clock_gating_set1_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, resetn, reg_write, reg_read, unit_access, unit_fault, irq;
  logic [1:0]  power_mode;
  logic [3:0]  unit_select;
  logic [8:0]  unit_clock_en;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  int          fails, checks_done, cyc, pos [9] = '{0, 1, 4, 5, 8, 12, 24, 25, 26};
  pcg_top i_dut (.*);
  task conclude;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected at %0t: %h vs %h", $time, g, e);
    end
  endtask : cmp
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    {reg_addr, reg_wdata, reg_write, reg_read} <= {a, d, w, !w};
    @(posedge clock);
    {reg_write, reg_read} <= 2'h0;
    #1 if (!w) cmp(reg_rdata, d);
  endtask : bus
  task acc(input logic [3:0] s, input logic e);
    @(posedge clock);
    {unit_select, unit_access} <= {s, 1'b1};
    @(posedge clock);
    unit_access <= 1'b0;
    #1 cmp({31'h0, unit_fault}, {31'h0, e});
  endtask : acc
  task out(input logic [1:0] m, input logic [9:0] e);
    @(posedge clock);
    power_mode <= m;
    repeat (2) @(posedge clock);
    #1 cmp({22'h0, irq, unit_clock_en}, {22'h0, e});
  endtask : out
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock)
    if (++cyc == 1500)
    begin
      fails++;
      conclude();
    end
  initial
  begin
    {resetn, reg_write, reg_read, unit_access, reg_addr, reg_wdata, power_mode, unit_select} = '0;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    out(2'h0, 10'h0);
    bus(0, 12'h124, 32'h0);
    for (int a = 'h104; a < 'h130; a += 'h10)
    begin
      bus(1, 12'(a), '1);
      bus(0, 12'(a), 32'h07001133);
    end
    bus(0, 12'h300, 32'h0);
    for (int i = 0; i < 9; i++)
    begin
      bus(1, 12'h104, 32'h1 << pos[i]);
      out(2'h0, 10'h1 << i);
      acc(4'(i), 1'b0);
      acc(4'((i + 1) % 9), 1'b1);
    end
    bus(1, 12'h104, 32'hf8ffeecc);
    out(2'h0, 10'h0);
    $display("gating test done");
    bus(1, 12'h114, 32'h2);
    bus(1, 12'h124, 32'h10);
    bus(1, 12'h104, 32'h1);
    out(2'h1, 10'h001);
    bus(1, 12'h060, 32'h08000000);
    out(2'h1, 10'h002);
    out(2'h2, 10'h004);
    bus(0, 12'h208, 32'h2);
    bus(0, 12'h060, 32'h08000000);
    out(2'h0, 10'h001);
    $display("mode test done");
    acc(4'h9, 1'b1);
    bus(1, 12'h200, 32'h3);
    acc(4'h1, 1'b1);
    bus(0, 12'h200, 32'h1);
    bus(1, 12'h204, 32'h1);
    out(2'h0, 10'h201);
    bus(1, 12'h200, 32'h1);
    out(2'h0, 10'h001);
    bus(1, 12'h204, 32'h2);
    bus(0, 12'h204, 32'h2);
    bus(1, 12'h104, 32'h3);
    out(2'h0, 10'h203);
    bus(0, 12'h200, 32'h2);
    $display("interrupt test done");
    conclude();
  end
endmodule : peripheral_clock_gating_set1_tb
